// ==== sim/xfs_host_model.sv ====
`timescale 1ns/10ps

// host computer and dry contacts on the far side of the supervisor
module xfs_host_model (
	input  wire logic i_sys_clk,
	output logic      o_host_msg,
	output logic      o_enable_contact,
	output logic      o_interlock_closed
);
	// contact already held at power-up, loop closed before any enable
	initial begin
		o_host_msg         = 1'b0;
		o_enable_contact   = 1'b1;
		o_interlock_closed = 1'b1;
	end

	// open or close the interlock loop
	task automatic set_loop(input logic v);
		@(posedge i_sys_clk);
		o_interlock_closed <= v;
	endtask : set_loop

	// release the contact for n cycles, then close it again
	task automatic reassert(input int n);
		@(posedge i_sys_clk);
		o_enable_contact <= 1'b0;
		repeat (n) @(posedge i_sys_clk);
		o_enable_contact <= 1'b1;
	endtask : reassert

	// one valid message from the host
	task automatic send_msg();
		@(posedge i_sys_clk);
		o_host_msg <= 1'b1;
		@(posedge i_sys_clk);
		o_host_msg <= 1'b0;
	endtask : send_msg
endmodule : xfs_host_model

// ==== sim/xfs_supervisor_tb.sv ====
`timescale 1ns/10ps
`include "xfs_cfg.svh"

module xfs_supervisor_tb
	import xfs_pkg::*;
();
	localparam xfs_cnt_t WD  = 32'hc8;
	localparam xfs_cnt_t WIN = 32'h12c;
	localparam xfs_cnt_t LED = 32'h14;

	logic                   i_sys_clk, i_reset, i_wr, i_rd, i_arc_det, on;
	logic [`XFS_ADDR_W-1:0] i_addr;
	logic [31:0]            i_wdata, d;
	logic [4:0]             trip;
	wire  [31:0]            o_rdata;
	wire  [4:0]             lamp;
	wire  [3:0]             code;
	wire  [15:0]            kv_sp, ma_sp;
	wire                    i_host_msg, i_enable_contact, i_interlock_closed;
	wire                    hv, relay, remote, arc_lamp, led, flt_o, flt_oe, st_o, st_oe;
	wire                    flt_pin, st_pin;
	int                     n_fail, compares, seed, k;

	xfs_supervisor #(.WD_CYC(WD), .ARC_WIN_CYC(WIN), .ARC_LED_CYC(LED)) u_xfs_supervisor (
		.i_sys_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_host_msg,
		.i_enable_contact, .i_interlock_closed, .i_arc_det, .i_ov_trip(trip[0]),
		.i_uv_trip(trip[1]), .i_oc_trip(trip[2]), .i_uc_trip(trip[3]), .i_ot_trip(trip[4]),
		.o_high_voltage_output(hv), .o_hv_relay(relay), .o_remote_mode(remote),
		.o_overvoltage_flag(lamp[0]), .o_undervoltage_flag(lamp[1]),
		.o_overcurrent_flag(lamp[2]), .o_undercurrent_flag(lamp[3]),
		.o_overtemp_flag(lamp[4]), .o_arc_fault_flag(arc_lamp), .o_xray_on_led(led),
		.o_summary_fault_out_o(flt_o), .o_summary_fault_out_oe(flt_oe),
		.o_xray_status_o(st_o), .o_xray_status_oe(st_oe), .o_fault_argument_code(code),
		.o_kv_setpoint(kv_sp), .o_ma_setpoint(ma_sp)
	);

	xfs_host_model u_xfs_host_model (
		.i_sys_clk, .o_host_msg(i_host_msg), .o_enable_contact(i_enable_contact),
		.o_interlock_closed(i_interlock_closed)
	);

	// open-collector pins with their pull-ups
	assign flt_pin = flt_oe ? flt_o : 1'b1;
	assign st_pin  = st_oe ? st_o : 1'b1;

	// free-running system clock
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	// wait cycles, then step off the edge to sample
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : tick

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [`XFS_ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge i_sys_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= v;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [`XFS_ADDR_W-1:0] a, input logic [31:0] exp,
			input logic [31:0] m);
		@(posedge i_sys_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		check(o_rdata & m, exp);
	endtask : rd

	task automatic arc();
		@(posedge i_sys_clk);
		i_arc_det <= 1'b1;
		@(posedge i_sys_clk);
		i_arc_det <= 1'b0;
	endtask : arc

	// bounded wait for the output state, a timeout ends the run
	task automatic wait_hv(input logic exp, input int lim);
		for (int i = 0; i < lim; i++) begin
			tick(1);
			if (hv === exp)
				break;
		end
		check(hv, exp);
		if (hv !== exp)
			finish_test();
	endtask : wait_hv

	function automatic xfs_code_t exp_code(input int n);
		case (n)
			0: return `XFS_CODE_OV;
			1: return `XFS_CODE_UV;
			2: return `XFS_CODE_OC;
			3: return `XFS_CODE_UC;
			default: return `XFS_CODE_OT;
		endcase
	endfunction : exp_code

	task automatic finish_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// main sequence
	initial begin
		seed = 32'haf57;
		i_reset = 1'b1;
		{i_wr, i_rd, i_arc_det} = 3'h0;
		i_addr = '0;
		i_wdata = '0;
		trip = '0;
		repeat (10) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		tick(4);
		check({hv, remote}, 2'b00);
		rd(`XFS_OFF_KV, 32'h0, 32'hffff);
		rd(`XFS_OFF_MA, 32'h0, 32'hffff);
		check({ma_sp, kv_sp}, 32'h0);
		u_xfs_host_model.reassert(3);
		wait_hv(1'b1, 10);
		check({relay, led, st_pin, flt_pin}, 4'b1101);
		// each comparator trip, cleared from the contact
		for (k = 0; k < 5; k++) begin
			on = (k == 3);
			@(posedge i_sys_clk);
			trip <= 5'h1 << k;
			@(posedge i_sys_clk);
			trip <= 5'h0;
			tick(2);
			check(lamp, 5'h1 << k);
			check(code, exp_code(k));
			check({hv, led, st_pin, flt_pin}, {on, on, ~on, 1'b0});
			u_xfs_host_model.reassert(k + 2);
			wait_hv(1'b1, 10);
			check({lamp, code}, 9'h0);
		end
		// loop opened while on, then a start with the loop open
		u_xfs_host_model.set_loop(1'b0);
		wait_hv(1'b0, 10);
		rd(`XFS_OFF_STATUS, 32'h0, 32'h4);
		u_xfs_host_model.reassert(3);
		tick(5);
		check({hv, code}, {1'b0, `XFS_CODE_ILK});
		check({arc_lamp, lamp, flt_pin}, 7'h0);
		u_xfs_host_model.set_loop(1'b1);
		u_xfs_host_model.reassert(3);
		wait_hv(1'b1, 10);
		check(code, `XFS_CODE_NONE);
		// remote control and arcs in a sliding window
		wr(`XFS_OFF_CMD, 32'h1);
		tick(1);
		check(remote, 1'b1);
		wait_hv(1'b1, 10);
		arc();
		tick(2);
		check({arc_lamp, hv, code}, {2'b11, `XFS_CODE_ARC});
		tick(LED + 2);
		check(arc_lamp, 1'b0);
		tick(WIN);
		arc();
		arc();
		tick(3);
		check(hv, 1'b1);
		arc();
		wait_hv(1'b0, 10);
		tick(LED + 2);
		check({arc_lamp, code}, {1'b1, `XFS_CODE_ARC});
		wr(`XFS_OFF_CMD, 32'h4);
		tick(2);
		check({arc_lamp, code}, 5'h0);
		rd(`XFS_OFF_ARCCNT, 32'h0, 32'h3);
		// single-arc shutdown, cleared by an on command
		wr(`XFS_OFF_CFG, 32'h2);
		wr(`XFS_OFF_CMD, 32'h1);
		wait_hv(1'b1, 10);
		arc();
		wait_hv(1'b0, 10);
		wr(`XFS_OFF_CMD, 32'h1);
		wait_hv(1'b1, 10);
		check(code, `XFS_CODE_NONE);
		// watchdog kept alive by messages, then left to expire
		wr(`XFS_OFF_CFG, 32'h1);
		repeat (3) begin
			tick(WD - 50);
			u_xfs_host_model.send_msg();
		end
		tick(WD - 10);
		check(hv, 1'b1);
		wait_hv(1'b0, 30);
		check(code, `XFS_CODE_WD);
		rd(`XFS_OFF_STATUS, 32'h4000, 32'h4000);
		wr(`XFS_OFF_CFG, 32'h0);
		// random setpoints, then the write-only command register and an unmapped place
		for (k = 0; k < 8; k++) begin
			d = $random(seed);
			wr(`XFS_OFF_KV, d);
			wr(`XFS_OFF_MA, ~d);
			rd(`XFS_OFF_KV, d & 32'hffff, 32'hffff);
			check({ma_sp, kv_sp}, {~d[15:0], d[15:0]});
		end
		rd(`XFS_OFF_CMD, 32'h0, 32'hffffffff);
		rd(5'h1c, 32'h0, 32'hffffffff);
		finish_test();
	end
endmodule : xfs_supervisor_tb

// ==== verilog/xfs_cfg.svh ====
`ifndef XFS_CFG_SVH
`define XFS_CFG_SVH

// clock rate
`define XFS_CLK_HZ        100000000

// register byte offsets
`define XFS_ADDR_W        5
`define XFS_OFF_CMD       5'h00
`define XFS_OFF_CFG       5'h04
`define XFS_OFF_KV        5'h08
`define XFS_OFF_MA        5'h0c
`define XFS_OFF_STATUS    5'h10
`define XFS_OFF_CODE      5'h14
`define XFS_OFF_ARCCNT    5'h18

// command and config bit positions, setpoint width and reset value
`define XFS_CMD_ON        0
`define XFS_CMD_OFF       1
`define XFS_CMD_CLR       2
`define XFS_CFG_WD_EN     0
`define XFS_CFG_ONE_ARC   1
`define XFS_SETP_W        16
`define XFS_SETP_RST      16'h0000

// fault flag indices
`define XFS_NFLAG         8
`define XFS_F_ARC         0
`define XFS_F_OV          1
`define XFS_F_UV          2
`define XFS_F_OC          3
`define XFS_F_UC          4
`define XFS_F_OT          5
`define XFS_F_WD          6
`define XFS_F_ILK         7
// flags that force high voltage off
`define XFS_SHUT_MASK     8'hef

// fault argument codes
`define XFS_CODE_NONE     4'h0
`define XFS_CODE_ARC      4'h1
`define XFS_CODE_OV       4'h3
`define XFS_CODE_UV       4'h4
`define XFS_CODE_OC       4'h5
`define XFS_CODE_UC       4'h6
`define XFS_CODE_OT       4'h6
`define XFS_CODE_WD       4'h5
`define XFS_CODE_ILK      4'h8

// timing
`define XFS_WD_TIME_S     10
`define XFS_WD_CYC        (`XFS_WD_TIME_S * `XFS_CLK_HZ)
`define XFS_ARC_WIN_S     10
`define XFS_ARC_WIN_CYC   (`XFS_ARC_WIN_S * `XFS_CLK_HZ)
`define XFS_ARC_LED_MS    1000
`define XFS_ARC_LED_CYC   (`XFS_ARC_LED_MS * (`XFS_CLK_HZ / 1000))
`define XFS_ARC_TRIP_N    2'd3

`endif

// ==== verilog/xfs_pkg.sv ====
package xfs_pkg;

	// control source
	typedef enum logic {
		XFS_LOCAL  = 1'b0,
		XFS_REMOTE = 1'b1
	} xfs_mode_t;

	typedef logic [7:0]  xfs_flag_t;
	typedef logic [3:0]  xfs_code_t;
	typedef logic [31:0] xfs_cnt_t;

endpackage : xfs_pkg

// ==== verilog/xfs_supervisor.sv ====
`timescale 1ns/10ps
`include "xfs_cfg.svh"

// Behaviour
// - internal fault latches flag, high voltage off
// - enabled watchdog stops output after ten seconds
// - setpoints read zero after power-up
// - start local, contact re-assertion needed
// - serial enable command selects remote mode
// - no enable while interlock loop open
// - interlock opening drops voltage; state readable
// - shutdown fault: power-down, lamp off, reported
// - local mode: contact re-assertion clears fault
// - remote mode: clear or on clears
// - interlock inhibit: code 8, no indicator
// - overvoltage: off, indicator, code 3
// - overcurrent: off, indicator, code 5
// - each arc: indicator one second, code 1
// - three arcs in ten seconds: shutdown
// - single-arc option shuts down first arc
// - undervoltage: off, indicator, code 4
// - undercurrent: indicator, code 6, stays on
// - overtemperature: off, indicator, code 6
// - watchdog expiry reported as code 5
// - summary output low on any fault
// - status output low and relay while on
module xfs_supervisor
	import xfs_pkg::*;
#(
	parameter xfs_cnt_t WD_CYC      = `XFS_WD_CYC,
	parameter xfs_cnt_t ARC_WIN_CYC = `XFS_ARC_WIN_CYC,
	parameter xfs_cnt_t ARC_LED_CYC = `XFS_ARC_LED_CYC
) (
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_reset,
	input  wire logic [`XFS_ADDR_W-1:0]   i_addr,
	input  wire logic [31:0]              i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [31:0]              o_rdata,
	input  wire logic                     i_host_msg,
	input  wire logic                     i_enable_contact,
	input  wire logic                     i_interlock_closed,
	input  wire logic                     i_arc_det,
	input  wire logic                     i_ov_trip,
	input  wire logic                     i_uv_trip,
	input  wire logic                     i_oc_trip,
	input  wire logic                     i_uc_trip,
	input  wire logic                     i_ot_trip,
	output logic                          o_high_voltage_output,
	output logic                          o_hv_relay,
	output logic                          o_remote_mode,
	output logic                          o_overvoltage_flag,
	output logic                          o_undervoltage_flag,
	output logic                          o_overcurrent_flag,
	output logic                          o_undercurrent_flag,
	output logic                          o_overtemp_flag,
	output logic                          o_arc_fault_flag,
	output logic                          o_xray_on_led,
	output logic                          o_summary_fault_out_o,
	output logic                          o_summary_fault_out_oe,
	output logic                          o_xray_status_o,
	output logic                          o_xray_status_oe,
	output logic      [3:0]               o_fault_argument_code,
	output logic      [`XFS_SETP_W-1:0]   o_kv_setpoint,
	output logic      [`XFS_SETP_W-1:0]   o_ma_setpoint
);

	xfs_mode_t               mode_q;
	logic                    hv_q, arc_lock_q;
	xfs_flag_t               flag_q, trip;
	xfs_code_t               code_q;
	logic                    wd_en_q, one_arc_q;
	logic [`XFS_SETP_W-1:0]  kv_q, ma_q;
	logic [31:0]             rdata_q;
	xfs_cnt_t                wd_cnt_q, age0_q, age1_q, led_cnt_q;
	logic                    contact_q, arc_det_q, val0_q, val1_q;
	logic                    cmd_wr, cmd_on, cmd_off, cmd_clr;
	logic                    contact_rise, arc_evt, arc_shut, clr;
	logic [1:0]              arc_recent;
	logic                    start_req, stop_req, shut_trip, shut_held;

	// command strobes from the register port
	assign cmd_wr  = i_wr && (i_addr == `XFS_OFF_CMD);
	assign cmd_on  = cmd_wr && i_wdata[`XFS_CMD_ON];
	assign cmd_off = cmd_wr && i_wdata[`XFS_CMD_OFF];
	assign cmd_clr = cmd_wr && i_wdata[`XFS_CMD_CLR];

	// edge detectors; contact history starts high so a held contact is no edge
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			contact_q <= 1'b1;
			arc_det_q <= 1'b0;
		end else begin
			contact_q <= i_enable_contact;
			arc_det_q <= i_arc_det;
		end
	end
	assign contact_rise = i_enable_contact && !contact_q;
	assign arc_evt      = i_arc_det && !arc_det_q;

	// fault reset event depends on control source
	assign clr = (mode_q == XFS_REMOTE) ? (cmd_clr || cmd_on)
	                                    : contact_rise;

	// start and stop requests per control source
	assign start_req = (mode_q == XFS_REMOTE) ? cmd_on : (contact_rise || cmd_on);
	assign stop_req  = (mode_q == XFS_REMOTE) ? cmd_off : !i_enable_contact;

	// control source: local after reset, remote after serial enable
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			mode_q <= XFS_LOCAL;
		end else if (cmd_on) begin
			mode_q <= XFS_REMOTE;
		end
	end

	// arc window: ages of the two latest arcs, dropped when older than window
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || clr) begin
			val0_q <= 1'b0;
			val1_q <= 1'b0;
			age0_q <= '0;
			age1_q <= '0;
		end else if (arc_evt) begin
			val0_q <= 1'b1;
			age0_q <= '0;
			val1_q <= val0_q;
			age1_q <= age0_q;
		end else begin
			age0_q <= val0_q ? age0_q + 32'h1 : age0_q;
			age1_q <= val1_q ? age1_q + 32'h1 : age1_q;
			if (age0_q >= ARC_WIN_CYC - 32'h1) begin
				val0_q <= 1'b0;
			end
			if (age1_q >= ARC_WIN_CYC - 32'h1) begin
				val1_q <= 1'b0;
			end
		end
	end
	assign arc_recent = {1'b0, val0_q} + {1'b0, val1_q};
	assign arc_shut   = arc_evt && (one_arc_q
	                    || (arc_recent + 2'd1 >= `XFS_ARC_TRIP_N));

	// arc indicator timer, reloaded by every arc
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			led_cnt_q <= '0;
		end else if (arc_evt) begin
			led_cnt_q <= ARC_LED_CYC;
		end else if (led_cnt_q != '0) begin
			led_cnt_q <= led_cnt_q - 32'h1;
		end
	end

	// host watchdog, restarted by any host message or register access
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !wd_en_q || i_host_msg || i_wr || i_rd) begin
			wd_cnt_q <= '0;
		end else if (wd_cnt_q <= WD_CYC) begin
			wd_cnt_q <= wd_cnt_q + 32'h1;
		end
	end

	// detected conditions this cycle
	always_comb begin
		trip              = '0;
		trip[`XFS_F_ARC]  = arc_evt;
		trip[`XFS_F_OV]   = i_ov_trip;
		trip[`XFS_F_UV]   = i_uv_trip;
		trip[`XFS_F_OC]   = i_oc_trip;
		trip[`XFS_F_UC]   = i_uc_trip;
		trip[`XFS_F_OT]   = i_ot_trip;
		trip[`XFS_F_WD]   = wd_en_q && (wd_cnt_q > WD_CYC);
		trip[`XFS_F_ILK]  = !i_interlock_closed && (hv_q || start_req);
	end

	// a lone arc latches its flag but is not a shutdown unless counted or one_arc_q is set
	assign shut_trip = |(trip & `XFS_SHUT_MASK & ~(8'h01 << `XFS_F_ARC)) || arc_shut;

	// shutdown faults still standing after this cycle's reset event
	assign shut_held = (|(flag_q & `XFS_SHUT_MASK & ~(8'h01 << `XFS_F_ARC)) || arc_lock_q)
	                   && !clr;

	// per-flag latch; a new event wins over a clear in the same cycle
	for (genvar g = 0; g < `XFS_NFLAG; g++) begin : g_flag
		always_ff @(posedge i_sys_clk) begin
			if (i_reset) begin
				flag_q[g] <= 1'b0;
			end else begin
				flag_q[g] <= trip[g] || (flag_q[g] && !clr);
			end
		end
	end

	// arc shutdown is remembered apart from the momentary arc flag
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			arc_lock_q <= 1'b0;
		end else begin
			arc_lock_q <= arc_shut || (arc_lock_q && !clr);
		end
	end

	// high voltage enable
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			hv_q <= 1'b0;
		end else if (shut_trip) begin
			hv_q <= 1'b0;
		end else if (start_req && i_interlock_closed && !shut_held) begin
			hv_q <= 1'b1;
		end else if (stop_req) begin
			hv_q <= 1'b0;
		end
	end

	// code of the highest priority condition
	function automatic xfs_code_t code_of(input xfs_flag_t t);
		xfs_code_t c;
		c = `XFS_CODE_NONE;
		if (t[`XFS_F_UC])  c = `XFS_CODE_UC;
		if (t[`XFS_F_ARC]) c = `XFS_CODE_ARC;
		if (t[`XFS_F_WD])  c = `XFS_CODE_WD;
		if (t[`XFS_F_OT])  c = `XFS_CODE_OT;
		if (t[`XFS_F_UV])  c = `XFS_CODE_UV;
		if (t[`XFS_F_OC])  c = `XFS_CODE_OC;
		if (t[`XFS_F_OV])  c = `XFS_CODE_OV;
		if (t[`XFS_F_ILK]) c = `XFS_CODE_ILK;
		code_of = c;
	endfunction : code_of

	// last reported fault code
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			code_q <= `XFS_CODE_NONE;
		end else if (trip != '0) begin
			code_q <= code_of(trip);
		end else if (clr) begin
			code_q <= `XFS_CODE_NONE;
		end
	end

	// software registers; setpoints zero after power-up
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			kv_q      <= `XFS_SETP_RST;
			ma_q      <= `XFS_SETP_RST;
			wd_en_q   <= 1'b0;
			one_arc_q <= 1'b0;
		end else if (i_wr) begin
			case (i_addr)
				`XFS_OFF_CFG: begin
					wd_en_q   <= i_wdata[`XFS_CFG_WD_EN];
					one_arc_q <= i_wdata[`XFS_CFG_ONE_ARC];
				end
				`XFS_OFF_KV: kv_q <= i_wdata[`XFS_SETP_W-1:0];
				`XFS_OFF_MA: ma_q <= i_wdata[`XFS_SETP_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// read data, valid the cycle after the read strobe
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rdata_q <= '0;
		end else if (i_rd) begin
			case (i_addr)
				`XFS_OFF_CFG:    rdata_q <= {30'h0, one_arc_q, wd_en_q};
				`XFS_OFF_KV:     rdata_q <= {16'h0, kv_q};
				`XFS_OFF_MA:     rdata_q <= {16'h0, ma_q};
				`XFS_OFF_STATUS: rdata_q <= {16'h0, flag_q, 4'h0, |flag_q,
				                  i_interlock_closed, mode_q, hv_q};
				`XFS_OFF_CODE:   rdata_q <= {28'h0, code_q};
				`XFS_OFF_ARCCNT: rdata_q <= {30'h0, arc_recent};
				default:         rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end
	assign o_rdata = rdata_q;

	// indicators; interlock inhibit has no lamp of its own
	assign o_overvoltage_flag    = flag_q[`XFS_F_OV];
	assign o_undervoltage_flag   = flag_q[`XFS_F_UV];
	assign o_overcurrent_flag    = flag_q[`XFS_F_OC];
	assign o_undercurrent_flag   = flag_q[`XFS_F_UC];
	assign o_overtemp_flag       = flag_q[`XFS_F_OT];
	assign o_arc_fault_flag      = arc_lock_q || (led_cnt_q != '0);
	assign o_xray_on_led         = hv_q;
	assign o_high_voltage_output = hv_q;
	assign o_hv_relay            = hv_q;
	assign o_remote_mode         = (mode_q == XFS_REMOTE);
	assign o_fault_argument_code = code_q;
	assign o_kv_setpoint         = kv_q;
	assign o_ma_setpoint         = ma_q;

	// open-collector pins pull low when active
	assign o_summary_fault_out_o  = 1'b0;
	assign o_summary_fault_out_oe = |flag_q;
	assign o_xray_status_o        = 1'b0;
	assign o_xray_status_oe       = hv_q;

	// checks
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);

	property p_fault_off;
		(i_ov_trip || i_uv_trip || i_oc_trip || i_ot_trip) |=> !hv_q && |flag_q;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault left hv on");
	// a higher priority trip in the same cycle may take the code
	property p_wd;
		(trip[`XFS_F_WD] && code_of(trip) == `XFS_CODE_WD)
		|=> flag_q[`XFS_F_WD] && !hv_q && code_q == `XFS_CODE_WD;
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog expiry missed");
	property p_setp_rst;
		@(posedge i_sys_clk) disable iff (1'b0) i_reset |=> kv_q == 16'h0 && ma_q == 16'h0;
	endproperty
	a_setp_rst: assert property (p_setp_rst) else $error("setpoint not zero");
	property p_start_local;
		@(posedge i_sys_clk) disable iff (1'b0) i_reset |=> mode_q == XFS_LOCAL && !hv_q;
	endproperty
	a_start_local: assert property (p_start_local) else $error("bad power-up mode");
	property p_remote;
		cmd_on |=> mode_q == XFS_REMOTE;
	endproperty
	a_remote: assert property (p_remote) else $error("remote not selected");
	property p_ilk_en;
		$rose(hv_q) |-> $past(i_interlock_closed);
	endproperty
	a_ilk_en: assert property (p_ilk_en) else $error("enabled with loop open");
	property p_ilk_drop;
		(hv_q && !i_interlock_closed) |=> !hv_q && flag_q[`XFS_F_ILK] && code_q == 4'h8;
	endproperty
	a_ilk_drop: assert property (p_ilk_drop) else $error("interlock open ignored");
	property p_local_hold;
		(mode_q == XFS_LOCAL && |flag_q && !contact_rise && !cmd_on) |=> |flag_q;
	endproperty
	a_local_hold: assert property (p_local_hold) else $error("fault cleared early");
	property p_remote_clr;
		(mode_q == XFS_REMOTE && cmd_clr && trip == '0) |=> flag_q == '0;
	endproperty
	a_remote_clr: assert property (p_remote_clr) else $error("clear ignored");
	property p_arc_led;
		arc_evt |=> o_arc_fault_flag [*4];
	endproperty
	a_arc_led: assert property (p_arc_led) else $error("arc lamp short");
	property p_one_arc;
		(arc_evt && one_arc_q) |=> !hv_q && arc_lock_q;
	endproperty
	a_one_arc: assert property (p_one_arc) else $error("single arc kept hv");
	// any detected condition pulls the summary pin low next cycle
	property p_summary;
		(trip != '0) |=> o_summary_fault_out_oe && !o_summary_fault_out_o;
	endproperty
	a_summary: assert property (p_summary) else $error("summary output wrong");
	property p_status;
		hv_q |-> o_xray_status_oe && o_hv_relay && o_xray_on_led;
	endproperty
	a_status: assert property (p_status) else $error("status pin wrong");

endmodule : xfs_supervisor
